// ### core/dcpl_pkg.sv
/*
 * Package for the decoder control pin logic: state carriers, reset
 * qualification count and two-wire bus address constants.
 * Assumes a single 40 MHz clock domain.
 */
`default_nettype none

package dcpl_pkg;

	localparam int unsigned RST_QUAL_CYCLES = 4;

	localparam logic [5:0] BUS_ADDR_BASE = 6'h22;
	localparam logic [6:0] BUS_ADDR_LOW  = {BUS_ADDR_BASE, 1'b0};
	localparam logic [6:0] BUS_ADDR_HIGH = {BUS_ADDR_BASE, 1'b1};

	typedef enum logic [1:0] {
		DCPL_RESETTING,
		DCPL_FLOATING,
		DCPL_DRIVING
	} dcpl_mode_e;

	typedef struct packed {
		logic level;
		logic en;
	} dcpl_pin_s;

	typedef struct packed {
		logic [2:0] cnt;
		logic       held;
	} dcpl_qual_s;

	typedef struct packed {
		dcpl_mode_e mode;
		dcpl_pin_s  blank;
		dcpl_pin_s  vbi;
		logic       irq_oe;
		logic [6:0] addr;
		logic       addr_match;
	} dcpl_state_s;

endpackage : dcpl_pkg

`default_nettype wire

// ### core/dcpl_reset_qual.sv
/*
 * Reset qualifier: reports a device reset once the reset pin has been
 * low for the qualifying number of clock cycles.
 * Assumes the reset pin is synchronous to clk.
 */
`timescale 1ns/100ps
`default_nettype none

module dcpl_reset_qual
	import dcpl_pkg::*;
#(
	parameter int unsigned QUAL_CYCLES = RST_QUAL_CYCLES
)
(
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic reset_pin_b,
	output logic      reset_hit
);

	// Counter is three bits wide, so longer qualification cannot be served
	if (QUAL_CYCLES < 1 || QUAL_CYCLES > 7)
	begin : g_bad_qual
		$error("QUAL_CYCLES out of range");
	end

	dcpl_qual_s q_r;
	dcpl_qual_s q_nxt;

	always_comb
	begin
		q_nxt = q_r;
		if (reset_pin_b)
		begin
			q_nxt.cnt  = 3'h0;
			q_nxt.held = 1'b0;
		end
		else if (q_r.cnt < 3'(QUAL_CYCLES))
		begin
			q_nxt.cnt = q_r.cnt + 3'h1;
		end
		// Pin low long enough: device reset
		if (!reset_pin_b && q_nxt.cnt >= 3'(QUAL_CYCLES))
			q_nxt.held = 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			q_r <= '0;
		else
			q_r <= q_nxt;
	end

	assign reset_hit = q_r.held;

	AST_QUAL_AFTER_LOW: assert property (@(posedge clk) disable iff (!rst_b)
		(!reset_pin_b)[*4] |=> reset_hit)
		else $error("reset not taken after four low cycles");

	AST_QUAL_NOT_SHORT: assert property (@(posedge clk) disable iff (!rst_b)
		reset_pin_b |=> !reset_hit)
		else $error("reset taken while pin high");

endmodule : dcpl_reset_qual

`default_nettype wire

// ### core/dcpl_top.sv
/*
 * Decoder control pin logic: blanking and VBI qualifier pins with
 * programmable polarity, open-drain interrupt request, qualified reset
 * input and strap-selected two-wire bus address.
 * Assumes all inputs synchronous to clk (the doubled pixel clock).
 */
`timescale 1ns/100ps
`default_nettype none

module dcpl_top
	import dcpl_pkg::*;
#(
	parameter int unsigned QUAL_CYCLES = RST_QUAL_CYCLES
)
(
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic       reset_pin_b,
	input  wire logic       soft_reset,
	input  wire logic       outputs_enable,
	input  wire logic       h_blank,
	input  wire logic       v_blank,
	input  wire logic       blank_pol_high,
	input  wire logic       vbi_data_valid,
	input  wire logic       vbi_pol_high,
	input  wire logic       irq_pending,
	input  wire logic       slave_addr_strap,
	input  wire logic [6:0] bus_addr_seen,
	output logic            blank_out,
	output logic            blank_oe,
	output logic            vbi_data_qualifier,
	output logic            vbi_data_qualifier_oe,
	output logic            interrupt_request_out,
	output logic            interrupt_request_out_oe,
	output logic [6:0]      own_bus_addr,
	output logic            bus_addr_match
);

	////////////////////////////////////////////////////////////////////////

	logic        reset_hit;
	dcpl_state_s s_r;
	dcpl_state_s s_nxt;

	// Qualification count must fit the three-bit counter of the qualifier
	if (QUAL_CYCLES < 1 || QUAL_CYCLES > 7)
	begin : g_bad_top_qual
		$error("QUAL_CYCLES not served by the reset qualifier");
	end

	dcpl_reset_qual #(
		.QUAL_CYCLES (QUAL_CYCLES)
	) dcpl_reset_qual_inst (
		.clk         (clk),
		.rst_b       (rst_b),
		.reset_pin_b (reset_pin_b),
		.reset_hit   (reset_hit)
	);

	function automatic logic pol(input logic active, input logic high_act);
		pol = high_act ? active : !active;
	endfunction : pol

	function automatic logic drives(input dcpl_mode_e state_mode);
		drives = (state_mode == DCPL_DRIVING);
	endfunction : drives

	////////////////////////////////////////////////////////////////////////

	always_comb
	begin
		s_nxt = s_r;
		// Levels, address and match follow their inputs one cycle late
		s_nxt.addr = slave_addr_strap ? BUS_ADDR_HIGH : BUS_ADDR_LOW;
		s_nxt.addr_match = (bus_addr_seen == s_nxt.addr);
		s_nxt.blank.level = pol(h_blank || v_blank, blank_pol_high);
		s_nxt.vbi.level = pol(vbi_data_valid, vbi_pol_high);
		s_nxt.irq_oe = irq_pending;
		case (s_r.mode)
			DCPL_RESETTING:
				if (!reset_hit)
					s_nxt.mode = DCPL_FLOATING;
			DCPL_FLOATING:
				if (outputs_enable)
					s_nxt.mode = DCPL_DRIVING;
			DCPL_DRIVING:
				if (!outputs_enable)
					s_nxt.mode = DCPL_FLOATING;
			default:
				s_nxt.mode = DCPL_RESETTING;
		endcase
		// Either reset restarts the float sequence and releases the interrupt line
		if (reset_hit || soft_reset)
		begin
			s_nxt.mode   = DCPL_RESETTING;
			s_nxt.irq_oe = 1'b0;
		end
		s_nxt.blank.en = drives(s_nxt.mode);
		s_nxt.vbi.en   = drives(s_nxt.mode);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			s_r      <= '0;
			s_r.mode <= DCPL_RESETTING;
			s_r.addr <= BUS_ADDR_LOW;
		end
		else
			s_r <= s_nxt;
	end

	assign blank_out                = s_r.blank.level;
	assign blank_oe                 = s_r.blank.en;
	assign vbi_data_qualifier       = s_r.vbi.level;
	assign vbi_data_qualifier_oe    = s_r.vbi.en;
	assign interrupt_request_out    = 1'b0;
	assign interrupt_request_out_oe = s_r.irq_oe;
	assign own_bus_addr             = s_r.addr;
	assign bus_addr_match           = s_r.addr_match;

	////////////////////////////////////////////////////////////////////////

	// Pin levels and polarity
	AST_BLANK_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> blank_out == ($past(h_blank || v_blank) ~^ $past(blank_pol_high)))
		else $error("blank level wrong");

	AST_VBI_LEVEL: assert property (@(posedge clk) disable iff (!rst_b)
		vbi_data_valid && vbi_pol_high |=> vbi_data_qualifier)
		else $error("vbi qualifier missed valid cycle");

	AST_VBI_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
		!vbi_data_valid && vbi_pol_high |=> !vbi_data_qualifier)
		else $error("vbi qualifier active without valid data");

	AST_VBI_POL: assert property (@(posedge clk) disable iff (!rst_b)
		!vbi_pol_high |=> vbi_data_qualifier == !$past(vbi_data_valid))
		else $error("vbi polarity wrong");

	// Float after either reset and until enabled
	AST_SOFT_FLOAT: assert property (@(posedge clk) disable iff (!rst_b)
		soft_reset |=> !blank_oe && !vbi_data_qualifier_oe)
		else $error("outputs driven after soft reset");

	AST_SOFT_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		soft_reset |=> !blank_oe ##1 !blank_oe)
		else $error("outputs driven too soon after soft reset");

	AST_HARD_FLOAT: assert property (@(posedge clk) disable iff (!rst_b)
		reset_hit |=> !blank_oe ##1 !blank_oe)
		else $error("outputs driven during device reset");

	AST_VBI_HARD_FLOAT: assert property (@(posedge clk) disable iff (!rst_b)
		reset_hit |=> !vbi_data_qualifier_oe ##1 !vbi_data_qualifier_oe)
		else $error("vbi qualifier driven during device reset");

	AST_FLOAT_AFTER_RESET: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(rst_b) |-> !blank_oe && !vbi_data_qualifier_oe)
		else $error("outputs driven right after hardware reset");

	AST_FLOAT_UNTIL_ENABLE: assert property (@(posedge clk) disable iff (!rst_b)
		!outputs_enable |=> !blank_oe && !vbi_data_qualifier_oe)
		else $error("outputs driven while not enabled");

	AST_DRIVE_GATE: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(blank_oe) |-> $past(outputs_enable) && !$past(soft_reset) && !$past(reset_hit))
		else $error("outputs started driving without enable");

	// Open-drain interrupt request
	AST_IRQ_OD: assert property (@(posedge clk) disable iff (!rst_b)
		!interrupt_request_out && (interrupt_request_out_oe == $past(irq_pending)
		|| $past(reset_hit || soft_reset)))
		else $error("interrupt pin not open drain");

	AST_IRQ_RELEASE: assert property (@(posedge clk) disable iff (!rst_b)
		!irq_pending |=> !interrupt_request_out_oe)
		else $error("interrupt line pulled without request");

	AST_IRQ_PULL: assert property (@(posedge clk) disable iff (!rst_b)
		irq_pending && !reset_hit && !soft_reset |=> interrupt_request_out_oe)
		else $error("interrupt line not pulled low on request");

	AST_IRQ_RESET: assert property (@(posedge clk) disable iff (!rst_b)
		reset_hit || soft_reset |=> !interrupt_request_out_oe)
		else $error("interrupt line pulled during reset");

	// Qualified reset pin and bus address
	AST_RESET_CHAIN: assert property (@(posedge clk) disable iff (!rst_b)
		(!reset_pin_b)[*4] |=> ##1 (!blank_oe && !interrupt_request_out_oe))
		else $error("long reset pulse did not reset");

	AST_ADDR: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> own_bus_addr == ($past(slave_addr_strap) ? 7'h45 : 7'h44))
		else $error("bus address wrong");

	AST_ADDR_MATCH: assert property (@(posedge clk) disable iff (!rst_b)
		1'b1 |=> bus_addr_match
		== ($past(bus_addr_seen) == ($past(slave_addr_strap) ? 7'h45 : 7'h44)))
		else $error("bus address match wrong");

	// Main scenarios
	COV_DRIVE: cover property (@(posedge clk) disable iff (!rst_b)
		!blank_oe ##1 blank_oe);
	COV_VBI: cover property (@(posedge clk) disable iff (!rst_b)
		vbi_data_qualifier_oe && vbi_data_qualifier);
	COV_IRQ: cover property (@(posedge clk) disable iff (!rst_b)
		interrupt_request_out_oe);
	COV_RESET: cover property (@(posedge clk) disable iff (!rst_b)
		blank_oe ##1 !blank_oe);
	COV_PIN_RESET: cover property (@(posedge clk) disable iff (!rst_b)
		reset_hit ##1 !reset_hit);

endmodule : dcpl_top

`default_nettype wire

// ### sim/dcpl_capture_model.sv
/*
 * Capture side model: resolves the pulled-up control pins as the
 * capture logic sees them.
 * Assumes each enable is high while the block drives its pin.
 */
`timescale 1ns/100ps
`default_nettype none

module dcpl_capture_model (
	input  wire logic blank_level,
	input  wire logic blank_en,
	input  wire logic vbi_level,
	input  wire logic vbi_en,
	input  wire logic irq_level,
	input  wire logic irq_en,
	output logic      blank_pin,
	output logic      vbi_pin,
	output logic      irq_pin
);
	// Released pins float up to the pull-up level
	assign blank_pin = blank_en ? blank_level : 1'b1;
	assign vbi_pin   = vbi_en ? vbi_level : 1'b1;
	assign irq_pin   = irq_en ? irq_level : 1'b1;
endmodule : dcpl_capture_model

`default_nettype wire

// ### sim/test_decoder_control_pin_logic.sv
/*
 * Testbench for the decoder control pin logic.
 * Assumes the capture model in the same folder.
 */
`timescale 1ns/100ps
`default_nettype none

module test_decoder_control_pin_logic;
	import dcpl_pkg::*;
	logic clk = 1'b0, rst_b = 1'b0, reset_pin_b = 1'b1, soft_reset = 1'b0;
	logic outputs_enable = 1'b1, h_blank = 1'b0, v_blank = 1'b0;
	logic blank_pol_high = 1'b0, vbi_data_valid = 1'b0, vbi_pol_high = 1'b0;
	logic irq_pending = 1'b0, slave_addr_strap = 1'b0;
	logic [6:0] bus_addr_seen = 7'h00, own_bus_addr;
	logic blank_out, blank_oe, vbi_data_qualifier, vbi_data_qualifier_oe;
	logic interrupt_request_out, interrupt_request_out_oe, bus_addr_match;
	logic blank_pin, vbi_pin, irq_pin;
	int   n_mismatch = 0, n_checks = 0;

	always #12.5 clk = ~clk;

	dcpl_top dcpl_top_inst (.clk, .rst_b, .reset_pin_b, .soft_reset, .outputs_enable,
		.h_blank, .v_blank, .blank_pol_high, .vbi_data_valid, .vbi_pol_high,
		.irq_pending, .slave_addr_strap, .bus_addr_seen, .blank_out, .blank_oe,
		.vbi_data_qualifier, .vbi_data_qualifier_oe, .interrupt_request_out,
		.interrupt_request_out_oe, .own_bus_addr, .bus_addr_match);

	dcpl_capture_model dcpl_capture_model_inst (.blank_level(blank_out),
		.blank_en(blank_oe), .vbi_level(vbi_data_qualifier),
		.vbi_en(vbi_data_qualifier_oe), .irq_level(interrupt_request_out),
		.irq_en(interrupt_request_out_oe), .blank_pin, .vbi_pin, .irq_pin);

	////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(negedge clk);
	endtask : step

	task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_drive;
		for (int k = 0; k < 10 && blank_oe !== 1'b1; k++)
			step();
		chk(blank_oe, 7'h01);
	endtask : wait_drive

	task automatic t_blank;
		for (int i = 0; i < 8; i++)
		begin
			{blank_pol_high, h_blank, v_blank} = i[2:0];
			step();
			chk(blank_pin, {(h_blank | v_blank) ~^ blank_pol_high});
		end
		$display("test blank done");
	endtask : t_blank

	task automatic t_vbi;
		for (int i = 0; i < 4; i++)
		begin
			{vbi_pol_high, vbi_data_valid} = i[1:0];
			step();
			chk(vbi_pin, {vbi_data_valid ~^ vbi_pol_high});
		end
		$display("test vbi done");
	endtask : t_vbi

	task automatic t_irq;
		for (int i = 0; i < 2; i++)
		begin
			irq_pending = i[0];
			step();
			chk(irq_pin, !i[0]);
			chk(interrupt_request_out_oe, i[0]);
		end
		$display("test irq done");
	endtask : t_irq

	task automatic t_addr;
		for (int i = 0; i < 4; i++)
		begin
			slave_addr_strap = i[1];
			bus_addr_seen = i[0] ? 7'h44 : 7'h45;
			step();
			chk(own_bus_addr, 7'h44 + i[1]);
			chk(bus_addr_match, i == 1 || i == 2);
		end
		$display("test addr done");
	endtask : t_addr

	task automatic t_soft;
		soft_reset = 1'b1;
		step();
		chk({blank_pin, vbi_pin, blank_oe, vbi_data_qualifier_oe}, 7'h0C);
		soft_reset = 1'b0;
		wait_drive();
		$display("test soft reset done");
	endtask : t_soft

	task automatic t_enable;
		outputs_enable = 1'b0;
		step();
		chk({blank_pin, vbi_pin, blank_oe, vbi_data_qualifier_oe}, 7'h0C);
		outputs_enable = 1'b1;
		wait_drive();
		$display("test enable done");
	endtask : t_enable

	task automatic t_pin;
		reset_pin_b = 1'b0;
		repeat (3) step();
		reset_pin_b = 1'b1;
		step();
		chk(blank_oe, 7'h01);
		reset_pin_b = 1'b0;
		repeat (4) step();
		reset_pin_b = 1'b1;
		step();
		chk({blank_pin, blank_oe, vbi_data_qualifier_oe}, 7'h04);
		wait_drive();
		$display("test reset pin done");
	endtask : t_pin

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : test_done

	initial
	begin
		repeat (5) step();
		rst_b = 1'b1;
		wait_drive();
		t_blank();
		t_vbi();
		t_irq();
		t_addr();
		t_soft();
		t_enable();
		t_pin();
		test_done();
	end

	initial
	begin
		#(2000 * 25);
		n_mismatch++;
		test_done();
	end
endmodule : test_decoder_control_pin_logic

`default_nettype wire
